// *** rtl/sbod_defs.svh ***
// Constants for the sixteen-bit opcode decoder: opcode patterns and field codes
`ifndef SBOD_DEFS_SVH
`define SBOD_DEFS_SVH
`define SBOD_OP_ESCAPE 8'h0F
`define SBOD_OP_PROT0 8'h00
`define SBOD_OP_PROT1 8'h01
`define SBOD_OP_LAR 8'h02
`define SBOD_OP_LSL 8'h03
`define SBOD_OP_ITER 8'hF3
`define SBOD_OP_ITER_NE 8'hF2
`define SBOD_OP_CALL_NEAR 8'hE8
`define SBOD_OP_CALL_FAR 8'h9A
`define SBOD_OP_BRA_NEAR 8'hE9
`define SBOD_OP_BRA_FAR 8'hEA
`define SBOD_OP_GRP_FF 8'hFF
`define SBOD_OP_EXIT_NEAR 8'hC3
`define SBOD_OP_EXIT_NEAR_IMM 8'hC2
`define SBOD_OP_EXIT_FAR 8'hCB
`define SBOD_OP_EXIT_FAR_IMM 8'hCA
`define SBOD_OP_INT_TYPE 8'hCD
`define SBOD_OP_INT3 8'hCC
`define SBOD_OP_INTO 8'hCE
`define SBOD_OP_TRAP_EXIT 8'hCF
`define SBOD_OP_ENTER 8'hC8
`define SBOD_OP_LEAVE 8'hC9
`define SBOD_OP_LOOP 8'hE2
`define SBOD_OP_LOOPZ 8'hE1
`define SBOD_OP_LOOPNZ 8'hE0
`define SBOD_OP_JCZ 8'hE3
`define SBOD_MOD_REG 2'h3
`define SBOD_MOD_DISP0 2'h0
`define SBOD_MOD_DISP8 2'h1
`define SBOD_RM_DIRECT 3'h6
`define SBOD_SHIFT_RESERVED 3'h6
`endif

// *** rtl/sbod_pkg.sv ***
// Types for the sixteen-bit opcode decoder
package sbod_pkg;
   typedef enum logic [5:0] {
      SBOD_OP_NONE = 6'h00, SBOD_OP_AND = 6'h01, SBOD_OP_TEST = 6'h02, SBOD_OP_OR = 6'h03,
      SBOD_OP_XOR = 6'h04, SBOD_OP_NOT = 6'h05, SBOD_OP_SHIFT = 6'h06,
      SBOD_OP_STG_COPY = 6'h07, SBOD_OP_STG_CMP = 6'h08, SBOD_OP_STG_SRCH = 6'h09,
      SBOD_OP_STG_FETCH = 6'h0A, SBOD_OP_STG_DEP = 6'h0B, SBOD_OP_STG_PIN = 6'h0C,
      SBOD_OP_STG_POUT = 6'h0D, SBOD_OP_CALL = 6'h0E, SBOD_OP_BRANCH = 6'h0F,
      SBOD_OP_EXIT = 6'h10, SBOD_OP_COND_BR = 6'h11, SBOD_OP_LOOP_BR = 6'h12,
      SBOD_OP_LOOPZ_BR = 6'h13, SBOD_OP_LOOPNZ_BR = 6'h14, SBOD_OP_COUNT_ZERO_BR = 6'h15,
      SBOD_OP_TRAP = 6'h16, SBOD_OP_TRAP_OVF = 6'h17, SBOD_OP_TRAP_EXIT = 6'h18,
      SBOD_OP_FRAME_SETUP = 6'h19, SBOD_OP_FRAME_DROP = 6'h1A,
      SBOD_OP_CLEAR_CARRY = 6'h1B, SBOD_OP_COMPL_CARRY = 6'h1C, SBOD_OP_SET_CARRY = 6'h1D,
      SBOD_OP_CLEAR_DIR = 6'h1E, SBOD_OP_SET_DIR = 6'h1F, SBOD_OP_CLEAR_IE = 6'h20,
      SBOD_OP_SET_IE = 6'h21, SBOD_OP_SAVE_GLOBAL = 6'h22, SBOD_OP_SAVE_VECTOR = 6'h23,
      SBOD_OP_LOAD_GLOBAL = 6'h24, SBOD_OP_LOAD_VECTOR = 6'h25, SBOD_OP_SAVE_MACHINE = 6'h26,
      SBOD_OP_LOAD_MACHINE = 6'h27, SBOD_OP_SAVE_LOCAL = 6'h28, SBOD_OP_SAVE_TASK = 6'h29,
      SBOD_OP_LOAD_LOCAL = 6'h2A, SBOD_OP_LOAD_TASK = 6'h2B, SBOD_OP_CHECK_RD = 6'h2C,
      SBOD_OP_CHECK_WR = 6'h2D, SBOD_OP_LOAD_RIGHTS = 6'h2E, SBOD_OP_LOAD_LIMIT = 6'h2F
   } sbod_op_t;
   typedef enum logic [2:0] {
      SBOD_SH_ROTATE_LEFT = 3'h0, SBOD_SH_ROTATE_RIGHT = 3'h1,
      SBOD_SH_ROTATE_CARRY_LEFT = 3'h2, SBOD_SH_ROTATE_CARRY_RIGHT = 3'h3,
      SBOD_SH_SHIFT_LEFT = 3'h4, SBOD_SH_SHIFT_LOGICAL_RIGHT = 3'h5,
      SBOD_SH_SHIFT_ARITH_RIGHT = 3'h7
   } sbod_shift_t;
   // Form: register/memory with register, immediate to r/m, immediate to accumulator
   typedef enum logic [1:0] {
      SBOD_FORM_RM_REG = 2'h0, SBOD_FORM_IMM_RM = 2'h1, SBOD_FORM_IMM_ACC = 2'h2,
      SBOD_FORM_OTHER = 2'h3
   } sbod_form_t;
   typedef enum logic [1:0] {
      SBOD_SEG_EXTRA = 2'h0, SBOD_SEG_CODE = 2'h1, SBOD_SEG_STACK = 2'h2, SBOD_SEG_DATA = 2'h3
   } sbod_seg_t;
   typedef enum logic [1:0] {
      SBOD_ITER_NONE = 2'h0, SBOD_ITER_ALWAYS = 2'h1, SBOD_ITER_WHILE_EQ = 2'h2,
      SBOD_ITER_WHILE_NE = 2'h3
   } sbod_iter_t;
   typedef enum logic [3:0] {
      SBOD_BASE_NONE = 4'h0, SBOD_BASE_BW_SI = 4'h1, SBOD_BASE_BW_DST = 4'h2,
      SBOD_BASE_FR_SI = 4'h3, SBOD_BASE_FR_DST = 4'h4, SBOD_BASE_SI = 4'h5,
      SBOD_BASE_DST = 4'h6, SBOD_BASE_FR = 4'h7, SBOD_BASE_BW = 4'h8
   } sbod_base_t;
   // One decoded instruction handed to the execution units
   typedef struct packed {
      sbod_op_t op;
      sbod_form_t form;
      logic invalid;
      logic wide;
      logic dir;
      sbod_shift_t shift_op;
      logic [1:0] shift_count_src;
      logic [3:0] cond;
      logic far;
      logic indirect;
      logic has_imm16;
      sbod_iter_t iter;
      logic reg_operand;
      logic [3:0] rm_reg;
      logic [3:0] reg_sel;
      sbod_base_t base;
      logic [15:0] disp;
      logic [15:0] imm;
      logic [7:0] imm2;
      sbod_seg_t seg;
      sbod_seg_t dest_seg;
   } sbod_decode_t;
endpackage : sbod_pkg

// *** rtl/sbod_byte_buf.sv ***
// Small register buffer holding the bytes of the instruction being decoded
`timescale 1ns/10ps
module sbod_byte_buf
   import sbod_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   input wire logic wr_en_i,
   input wire logic [3:0] wr_idx_i,
   input wire logic [7:0] wr_data_i,
   output logic [127:0] rd_data_o
);
   logic [7:0] mem_reg [0:15];
   logic [7:0] mem_next [0:15];

   //==========================================
   // Storage update
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         mem_next[i] = clear_i ? 8'h00 : mem_reg[i];
      end
      if (wr_en_i)
      begin
         mem_next[wr_idx_i] = wr_data_i;
      end
   end

   // Read data comes from a register so it lines up with the stored bytes
   always_ff @(posedge ref_clk_i)
   begin
      for (int i = 0; i < 16; i++)
      begin
         mem_reg[i] <= rst_b_i ? mem_next[i] : 8'h00;
      end
   end

   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         rd_data_o[i*8 +: 8] = mem_reg[i];
      end
   end
endmodule : sbod_byte_buf

// *** rtl/sbod_decoder.sv ***
// Sixteen-bit opcode decoder: logic, string, control, flag and protection opcodes
//==========================================
// What this block does
// - AND decoded as 001000dw, 1000000w ext 100, and 0010010w.
// - Flag-only AND: 1000010w, 1111011w ext 000, 1010100w; result discarded.
// - OR decoded as 000010dw, 1000000w ext 001, and 0000110w.
// - XOR as 001100dw, 1000000w ext 110, 0011010w; inversion 1111011w ext 010.
// - Single-byte string primitives, bit 0 selecting byte or word width.
// - 11110011 repeats unconditionally; 1111001z repeats compare/search on equal or not.
// - Calls: E8 near, 9A far direct, FF ext 010/011 indirect.
// - Branches: E9 near, EA far direct, FF ext 100/101 indirect.
// - Exits C3, CB; C2, CA carry a 16-bit stack adjustment.
// - Conditional branch 0111cccc with one displacement byte, nibble is the condition.
// - Counted branches E2, E1, E0 and count-zero E3 with one displacement byte.
// - Traps CD with type byte, CC type 3, CE on overflow, CF trap exit.
// - Frame setup C8 with 16-bit size and level byte; teardown C9.
// - Single-byte flag controls for carry, direction and interrupt enable.
// - 0F 01 extensions: save/load global and vector tables, machine word.
// - 0F 00 local table, task register, read/write checks; 0F 02/03 rights, limit.
// - Addressing form: 11 register, 00 none, 01 sign-extended byte, 10 word.
// - Selector field picks base and index registers; 110 with form 00 is direct.
// - Byte 001rr110 overrides segment: extra, code, stack, data.
// - Register field maps words and byte low/high halves by width.
// - Frame-based operands default to stack unless overridden; string destinations always use extra segment.
// - Shift group opcodes D0/D1 by one, D2/D3 by count, C0/C1 by immediate.
`timescale 1ns/10ps
`include "sbod_defs.svh"
module sbod_decoder
   import sbod_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_data_i,
   output logic byte_ready_o,
   output logic dec_valid_o,
   output sbod_decode_t dec_o
);
   typedef enum logic [2:0] {
      SBOD_ST_COLLECT = 3'b001,
      SBOD_ST_EMIT = 3'b010,
      SBOD_ST_HOLD = 3'b100
   } sbod_state_t;

   sbod_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [127:0] bytes;
   sbod_decode_t dec_reg, dec_next;
   logic valid_reg, valid_next;
   logic [7:0] buf_b [0:15];
   logic [7:0] cur_b [0:15];
   logic [3:0] need;
   logic done;
   sbod_decode_t cand;

   // Byte buffer; the decoder reads the stored bytes plus the one arriving now
   sbod_byte_buf u_buf (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .clear_i(state_reg == SBOD_ST_EMIT),
      .wr_en_i(byte_valid_i && byte_ready_o),
      .wr_idx_i(cnt_reg),
      .wr_data_i(byte_data_i),
      .rd_data_o(bytes)
   );

   //==========================================
   // Helper functions
   // Bytes of displacement implied by form and selector
   function automatic logic [1:0] disp_len(input logic [7:0] mrm);
      if (mrm[7:6] == `SBOD_MOD_REG) disp_len = 2'd0;
      else if (mrm[7:6] == `SBOD_MOD_DISP0)
         disp_len = (mrm[2:0] == `SBOD_RM_DIRECT) ? 2'd2 : 2'd0;
      else if (mrm[7:6] == `SBOD_MOD_DISP8) disp_len = 2'd1;
      else disp_len = 2'd2;
   endfunction : disp_len

   // Immediate length for data that follows, by width bit
   function automatic logic [3:0] imm_len(input logic w);
      imm_len = w ? 4'd2 : 4'd1;
   endfunction : imm_len

   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         buf_b[i] = bytes[i*8 +: 8];
         cur_b[i] = (4'(i) == cnt_reg) ? byte_data_i : buf_b[i];
      end
   end

   //==========================================
   // Decode of the bytes gathered so far; prefixes shift the opcode position
   always_comb
   begin
      logic [3:0] p;
      logic [7:0] op;
      logic [7:0] mrm;
      logic [7:0] op2;
      logic [3:0] mpos;
      logic modrm;
      logic [3:0] extra;
      logic [2:0] ext;
      p = 4'd0;
      cand = '0;
      cand.seg = SBOD_SEG_DATA;
      cand.dest_seg = SBOD_SEG_EXTRA;
      cand.form = SBOD_FORM_OTHER;
      modrm = 1'b0;
      extra = 4'd0;
      mpos = 4'd1;
      if (cnt_reg >= 4'd1 && buf_b[0][7:5] == 3'b001 && buf_b[0][2:0] == 3'b110)
      begin
         cand.seg = sbod_seg_t'(buf_b[0][4:3]);
         p = 4'd1;
      end
      if (cnt_reg > p && (buf_b[p] == `SBOD_OP_ITER || buf_b[p] == `SBOD_OP_ITER_NE))
      begin
         cand.iter = (buf_b[p] == `SBOD_OP_ITER) ? SBOD_ITER_ALWAYS : SBOD_ITER_WHILE_NE;
         p = p + 4'd1;
      end
      op = cur_b[p];
      op2 = cur_b[p + 4'd1];
      mrm = cur_b[p + 4'd1];
      ext = mrm[5:3];
      mpos = p + 4'd1;
      cand.wide = op[0];
      cand.dir = op[1];
      cand.invalid = 1'b0;
      if (op[7:2] == 6'b001000 || op[7:2] == 6'b000010 || op[7:2] == 6'b001100)
      begin
         cand.op = (op[5:4] == 2'b10) ? SBOD_OP_AND : (op[5] ? SBOD_OP_XOR : SBOD_OP_OR);
         cand.form = SBOD_FORM_RM_REG;
         modrm = 1'b1;
      end
      else if (op[7:1] == 7'b0010010 || op[7:1] == 7'b0000110 || op[7:1] == 7'b0011010
               || op[7:1] == 7'b1010100)
      begin
         cand.op = (op[7:1] == 7'b0010010) ? SBOD_OP_AND :
                   (op[7:1] == 7'b0000110) ? SBOD_OP_OR :
                   (op[7:1] == 7'b0011010) ? SBOD_OP_XOR : SBOD_OP_TEST;
         cand.form = SBOD_FORM_IMM_ACC;
         extra = imm_len(op[0]);
      end
      else if (op[7:1] == 7'b1000000)
      begin
         modrm = 1'b1;
         cand.form = SBOD_FORM_IMM_RM;
         extra = imm_len(op[0]);
         unique case (ext)
            3'b100: cand.op = SBOD_OP_AND;
            3'b001: cand.op = SBOD_OP_OR;
            3'b110: cand.op = SBOD_OP_XOR;
            default: cand.invalid = 1'b1;
         endcase
      end
      else if (op[7:1] == 7'b1000010)
      begin
         cand.op = SBOD_OP_TEST;
         cand.form = SBOD_FORM_RM_REG;
         modrm = 1'b1;
      end
      else if (op[7:1] == 7'b1111011)
      begin
         modrm = 1'b1;
         if (ext == 3'b000)
         begin
            cand.op = SBOD_OP_TEST;
            cand.form = SBOD_FORM_IMM_RM;
            extra = imm_len(op[0]);
         end
         else if (ext == 3'b010)
            cand.op = SBOD_OP_NOT;
         else
            cand.invalid = 1'b1;
      end
      else if (op[7:1] == 7'b1101000 || op[7:1] == 7'b1101001 || op[7:1] == 7'b1100000)
      begin
         // shift groups; shift field, code 110 undefined
         cand.op = SBOD_OP_SHIFT;
         modrm = 1'b1;
         cand.shift_op = sbod_shift_t'(ext);
         cand.shift_count_src = (op[7:1] == 7'b1100000) ? 2'd2 : {1'b0, op[1]};
         extra = (op[7:1] == 7'b1100000) ? 4'd1 : 4'd0;
         cand.invalid = (ext == `SBOD_SHIFT_RESERVED);
      end
      else if (op[7:1] == 7'b1010010 || op[7:1] == 7'b1010011 || op[7:1] == 7'b1010111
               || op[7:1] == 7'b1010110 || op[7:1] == 7'b1010101
               || op[7:1] == 7'b0110110 || op[7:1] == 7'b0110111)
      begin
         unique case (op[7:1])
            7'b1010010: cand.op = SBOD_OP_STG_COPY;
            7'b1010011: cand.op = SBOD_OP_STG_CMP;
            7'b1010111: cand.op = SBOD_OP_STG_SRCH;
            7'b1010110: cand.op = SBOD_OP_STG_FETCH;
            7'b1010101: cand.op = SBOD_OP_STG_DEP;
            7'b0110110: cand.op = SBOD_OP_STG_PIN;
            default: cand.op = SBOD_OP_STG_POUT;
         endcase
         // conditional repeat only for compare and search
         if (cand.iter != SBOD_ITER_NONE && (cand.op == SBOD_OP_STG_CMP
             || cand.op == SBOD_OP_STG_SRCH))
            cand.iter = (p != 4'd0 && buf_b[p - 4'd1][0]) ? SBOD_ITER_WHILE_EQ
                        : SBOD_ITER_WHILE_NE;
         else if (cand.iter == SBOD_ITER_WHILE_NE)
            cand.invalid = 1'b1;
      end
      else if (op == `SBOD_OP_CALL_NEAR || op == `SBOD_OP_BRA_NEAR)
      begin
         cand.op = (op == `SBOD_OP_CALL_NEAR) ? SBOD_OP_CALL : SBOD_OP_BRANCH;
         extra = 4'd2;
      end
      else if (op == `SBOD_OP_CALL_FAR || op == `SBOD_OP_BRA_FAR)
      begin
         cand.op = (op == `SBOD_OP_CALL_FAR) ? SBOD_OP_CALL : SBOD_OP_BRANCH;
         cand.far = 1'b1;
         extra = 4'd4;
      end
      else if (op == `SBOD_OP_GRP_FF)
      begin
         modrm = 1'b1;
         cand.indirect = 1'b1;
         cand.far = ext[0];
         unique case (ext)
            3'b010, 3'b011: cand.op = SBOD_OP_CALL;
            3'b100, 3'b101: cand.op = SBOD_OP_BRANCH;
            default: cand.invalid = 1'b1;
         endcase
      end
      else if (op == `SBOD_OP_EXIT_NEAR || op == `SBOD_OP_EXIT_FAR
               || op == `SBOD_OP_EXIT_NEAR_IMM || op == `SBOD_OP_EXIT_FAR_IMM)
      begin
         // exits, immediate added to stack pointer after the pop
         cand.op = SBOD_OP_EXIT;
         cand.far = op[3];
         cand.has_imm16 = ~op[0];
         extra = op[0] ? 4'd0 : 4'd2;
      end
      else if (op[7:4] == 4'b0111)
      begin
         cand.op = SBOD_OP_COND_BR;
         cand.cond = op[3:0];
         extra = 4'd1;
      end
      else if (op[7:2] == 6'b111000)
      begin
         unique case (op[1:0])
            2'b10: cand.op = SBOD_OP_LOOP_BR;
            2'b01: cand.op = SBOD_OP_LOOPZ_BR;
            2'b00: cand.op = SBOD_OP_LOOPNZ_BR;
            default: cand.op = SBOD_OP_COUNT_ZERO_BR;
         endcase
         extra = 4'd1;
      end
      else if (op[7:2] == 6'b110011)
      begin
         // traps; type 3 reported in the immediate
         unique case (op[1:0])
            2'b01: cand.op = SBOD_OP_TRAP;
            2'b00: cand.op = SBOD_OP_TRAP;
            2'b10: cand.op = SBOD_OP_TRAP_OVF;
            default: cand.op = SBOD_OP_TRAP_EXIT;
         endcase
         extra = (op == `SBOD_OP_INT_TYPE) ? 4'd1 : 4'd0;
      end
      else if (op == `SBOD_OP_ENTER || op == `SBOD_OP_LEAVE)
      begin
         cand.op = (op == `SBOD_OP_ENTER) ? SBOD_OP_FRAME_SETUP : SBOD_OP_FRAME_DROP;
         extra = (op == `SBOD_OP_ENTER) ? 4'd3 : 4'd0;
      end
      else if (op == 8'hF8 || op == 8'hF5 || op == 8'hF9 || op == 8'hFC || op == 8'hFD
               || op == 8'hFA || op == 8'hFB)
      begin
         unique case (op[3:0])
            4'h8: cand.op = SBOD_OP_CLEAR_CARRY;
            4'h5: cand.op = SBOD_OP_COMPL_CARRY;
            4'h9: cand.op = SBOD_OP_SET_CARRY;
            4'hC: cand.op = SBOD_OP_CLEAR_DIR;
            4'hD: cand.op = SBOD_OP_SET_DIR;
            4'hA: cand.op = SBOD_OP_CLEAR_IE;
            default: cand.op = SBOD_OP_SET_IE;
         endcase
      end
      else if (op == `SBOD_OP_ESCAPE)
      begin
         mrm = cur_b[p + 4'd2];
         ext = mrm[5:3];
         mpos = (op2[7:2] == 6'b000000) ? p + 4'd2 : p + 4'd1;
         modrm = 1'b1;
         unique case (op2)
            `SBOD_OP_PROT1:
               unique case (ext)
                  3'b000: cand.op = SBOD_OP_SAVE_GLOBAL;
                  3'b001: cand.op = SBOD_OP_SAVE_VECTOR;
                  3'b010: cand.op = SBOD_OP_LOAD_GLOBAL;
                  3'b011: cand.op = SBOD_OP_LOAD_VECTOR;
                  3'b100: cand.op = SBOD_OP_SAVE_MACHINE;
                  3'b110: cand.op = SBOD_OP_LOAD_MACHINE;
                  default: cand.invalid = 1'b1;
               endcase
            `SBOD_OP_PROT0:
               unique case (ext)
                  3'b000: cand.op = SBOD_OP_SAVE_LOCAL;
                  3'b001: cand.op = SBOD_OP_SAVE_TASK;
                  3'b010: cand.op = SBOD_OP_LOAD_LOCAL;
                  3'b011: cand.op = SBOD_OP_LOAD_TASK;
                  3'b100: cand.op = SBOD_OP_CHECK_RD;
                  3'b101: cand.op = SBOD_OP_CHECK_WR;
                  default: cand.invalid = 1'b1;
               endcase
            `SBOD_OP_LAR: cand.op = SBOD_OP_LOAD_RIGHTS;
            `SBOD_OP_LSL: cand.op = SBOD_OP_LOAD_LIMIT;
            default: cand.invalid = 1'b1;
         endcase
      end
      else
      begin
         // anything else is reported as invalid
         cand.invalid = 1'b1;
      end
      // a repeat prefix is only legal before a string primitive
      if (cand.iter != SBOD_ITER_NONE && (cand.op < SBOD_OP_STG_COPY
          || cand.op > SBOD_OP_STG_POUT))
         cand.invalid = 1'b1;
      // length: opcode, operand byte, displacement, then data
      if (cand.invalid)
         need = p;
      else if (modrm)
         need = mpos + (cnt_reg >= mpos ? 4'(disp_len(mrm)) : 4'd0) + extra;
      else
         need = p + extra;
      // An extension code is only judged once its byte has arrived
      done = (cnt_reg >= need) && !(modrm && cnt_reg < mpos)
             && !(cnt_reg == p && ((p == 4'd0 && op[7:5] == 3'b001 && op[2:0] == 3'b110)
                  || (cand.iter == SBOD_ITER_NONE
                      && (op == `SBOD_OP_ITER || op == `SBOD_OP_ITER_NE))));
      cand.reg_operand = modrm && (mrm[7:6] == `SBOD_MOD_REG);
      // register codes carry width as their top bit
      cand.rm_reg = {cand.wide, mrm[2:0]};
      cand.reg_sel = {cand.wide, mrm[5:3]};
      if (modrm && !cand.reg_operand)
      begin
         if (mrm[7:6] == `SBOD_MOD_DISP0 && mrm[2:0] == `SBOD_RM_DIRECT)
            cand.base = SBOD_BASE_NONE;
         else
            cand.base = sbod_base_t'({1'b0, mrm[2:0]} + 4'd1);
         unique case (disp_len(mrm))
            2'd1: cand.disp = {{8{cur_b[mpos + 4'd1][7]}}, cur_b[mpos + 4'd1]};
            2'd2: cand.disp = {cur_b[mpos + 4'd2], cur_b[mpos + 4'd1]};
            default: cand.disp = 16'h0000;
         endcase
         // frame register defaults to stack unless overridden
         if (p == 4'd0 || cand.seg == SBOD_SEG_DATA)
            if (cand.base == SBOD_BASE_FR_SI || cand.base == SBOD_BASE_FR_DST
                || cand.base == SBOD_BASE_FR)
               cand.seg = (buf_b[0][7:5] == 3'b001 && buf_b[0][2:0] == 3'b110 && p != 4'd0)
                          ? cand.seg : SBOD_SEG_STACK;
      end
      // Immediate data or branch displacement after any operand bytes
      begin
         logic [3:0] ip;
         ip = need - extra + 4'd1;
         cand.imm = (extra >= 4'd2) ? {cur_b[ip + 4'd1], cur_b[ip]} :
                    (extra == 4'd1) ? {8'h00, cur_b[ip]} : 16'h0000;
         cand.imm2 = (extra == 4'd3) ? cur_b[ip + 4'd2] : 8'h00;
         if (op == `SBOD_OP_INT3 && cand.op == SBOD_OP_TRAP)
            cand.imm = 16'h0003;
      end
      // string destination always in extra segment
      cand.dest_seg = SBOD_SEG_EXTRA;
   end

   //==========================================
   // Sequencing: gather bytes, present one decode per instruction
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      dec_next = dec_reg;
      valid_next = 1'b0;
      unique case (state_reg)
         SBOD_ST_COLLECT:
            if (byte_valid_i)
            begin
               if (done)
               begin
                  dec_next = cand;
                  valid_next = 1'b1;
                  state_next = SBOD_ST_EMIT;
               end
               cnt_next = cnt_reg + 4'd1;
            end
         SBOD_ST_EMIT:
         begin
            cnt_next = 4'd0;
            state_next = SBOD_ST_COLLECT;
         end
         default: state_next = SBOD_ST_COLLECT;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         state_reg <= SBOD_ST_COLLECT;
         cnt_reg <= 4'd0;
         dec_reg <= '0;
         valid_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         dec_reg <= dec_next;
         valid_reg <= valid_next;
      end
   end

   assign byte_ready_o = (state_reg == SBOD_ST_COLLECT);
   assign dec_valid_o = valid_reg;
   assign dec_o = dec_reg;
endmodule : sbod_decoder

// *** test/sbod_fetch_model.sv ***
// Fetch unit model feeding opcode bytes to the decoder
`timescale 1ns/10ps
module sbod_fetch_model
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic byte_ready_i,
   output logic byte_valid_o,
   output logic [7:0] byte_data_o
);
   logic [7:0] q [$];
   logic slow = 1'b0;
   logic gap = 1'b0;
   logic keep;
   initial byte_valid_o = 1'b0;
   initial byte_data_o = 8'h00;
   // ==========
   // A refused byte is held; idle data toggles so a stale byte never looks valid
   always @(posedge ref_clk_i)
   begin
      keep = byte_valid_o && !byte_ready_i;
      if (byte_valid_o && byte_ready_i)
         void'(q.pop_front());
      gap = ~gap;
      #1;
      if (!keep && rst_b_i && q.size() > 0 && !(slow && gap))
      begin
         byte_valid_o = 1'b1;
         byte_data_o = q[0];
      end
      else if (!keep)
      begin
         byte_valid_o = 1'b0;
         byte_data_o = ~byte_data_o;
      end
   end
endmodule : sbod_fetch_model

// *** test/sbod_decoder_props.sv ***
// Checker for the decoder handshake and chosen decodes
`timescale 1ns/10ps
module sbod_decoder_props
   import sbod_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_data_i,
   input wire logic byte_ready_o,
   input wire logic dec_valid_o,
   input wire sbod_decode_t dec_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic take;
   logic start_reg, start_next;
   logic [7:0] first_reg, first_next;
   assign take = byte_valid_i && byte_ready_o;
   // ==========
   // First byte of each instruction
   always_comb
   begin
      start_next = dec_valid_o ? 1'b1 : (take ? 1'b0 : start_reg);
      first_next = (take && start_reg) ? byte_data_i : first_reg;
   end
   always_ff @(posedge ref_clk_i)
   begin
      start_reg <= rst_b_i ? start_next : 1'b1;
      first_reg <= rst_b_i ? first_next : 8'h00;
   end
   pulse_one_a: assert property (dec_valid_o |=> !dec_valid_o)
      else $error("decode valid too long");
   ready_gap_a: assert property (byte_ready_o != dec_valid_o)
      else $error("ready not low in decode cycle only");
   valid_cause_a: assert property (dec_valid_o |-> $past(take))
      else $error("decode without final byte");
   result_hold_a: assert property (!dec_valid_o |-> $stable(dec_o))
      else $error("decode result moved");
   carry_clear_a: assert property (start_reg && take && byte_data_i == 8'hF8 |=>
      dec_valid_o && dec_o.op == SBOD_OP_CLEAR_CARRY) else $error("clear carry missed");
   trap_three_a: assert property (start_reg && take && byte_data_i == 8'hCC |=>
      dec_valid_o && dec_o.imm == 16'h0003) else $error("type 3 trap missed");
   cond_nibble_a: assert property (dec_valid_o && dec_o.op == SBOD_OP_COND_BR |->
      dec_o.cond == first_reg[3:0]) else $error("condition nibble wrong");
   dest_extra_a: assert property (dec_valid_o && dec_o.op == SBOD_OP_STG_COPY |->
      dec_o.dest_seg == SBOD_SEG_EXTRA) else $error("string destination segment");
   cover property (dec_valid_o && dec_o.invalid);
   cover property (dec_valid_o && dec_o.iter == SBOD_ITER_WHILE_NE);
   cover property (dec_valid_o && dec_o.op == SBOD_OP_COND_BR);
endmodule : sbod_decoder_props
bind sbod_decoder sbod_decoder_props u_sbod_decoder_props (.ref_clk_i(ref_clk_i),
   .rst_b_i(rst_b_i), .byte_valid_i(byte_valid_i), .byte_data_i(byte_data_i),
   .byte_ready_o(byte_ready_o), .dec_valid_o(dec_valid_o), .dec_o(dec_o));

// *** test/tb_sbod_decoder.sv ***
// Testbench for the opcode decoder
`timescale 1ns/10ps
module tb_sbod_decoder
   import sbod_pkg::*;
   ;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic bv, br, dv;
   logic [7:0] bd;
   sbod_decode_t dec, d;
   sbod_decode_t dq [$];
   int fail_count = 0;
   int n_checks = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   sbod_decoder u_sbod_decoder (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .byte_valid_i(bv),
      .byte_data_i(bd), .byte_ready_o(br), .dec_valid_o(dv), .dec_o(dec));
   sbod_fetch_model u_sbod_fetch_model (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .byte_ready_i(br), .byte_valid_o(bv), .byte_data_o(bd));
   // ==========
   // Collect every decode
   always @(posedge ref_clk_i)
   begin
      if (dv === 1'b1)
         dq.push_back(dec);
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic run(input logic [7:0] b [$], input int n);
      int k = 0;
      foreach (b[i]) u_sbod_fetch_model.q.push_back(b[i]);
      while (dq.size() < n && k < 200)
      begin
         @(posedge ref_clk_i);
         k++;
      end
      chk("decodes", 16'(n), 16'(dq.size()));
   endtask : run
   task automatic t_flags;
      sbod_op_t e [$] = '{SBOD_OP_CLEAR_CARRY, SBOD_OP_COMPL_CARRY, SBOD_OP_SET_CARRY,
         SBOD_OP_CLEAR_DIR, SBOD_OP_SET_DIR, SBOD_OP_CLEAR_IE, SBOD_OP_SET_IE};
      run('{8'hF8, 8'hF5, 8'hF9, 8'hFC, 8'hFD, 8'hFA, 8'hFB}, 7);
      foreach (e[i])
      begin
         d = dq.pop_front();
         chk("flag op", 16'(e[i]), 16'(d.op));
      end
   endtask : t_flags
   task automatic t_misc;
      run('{8'h74, 8'h10, 8'hC2, 8'h34, 8'h12, 8'h21, 8'h46, 8'hF0, 8'h26, 8'hFF, 8'h5E,
         8'h08, 8'hC1, 8'hF8, 8'h03, 8'hC8, 8'h10, 8'h00, 8'h02, 8'h0F, 8'h00, 8'hD8}, 7);
      d = dq.pop_front();
      chk("cond", 16'h0004, 16'(d.cond));
      chk("cond disp", 16'h0010, d.imm);
      d = dq.pop_front();
      chk("exit imm", 16'h1234, d.imm);
      chk("exit op", 16'(SBOD_OP_EXIT), 16'(d.op));
      d = dq.pop_front();
      chk("and op", 16'(SBOD_OP_AND), 16'(d.op));
      chk("disp sext", 16'hFFF0, d.disp);
      chk("base", 16'(SBOD_BASE_FR), 16'(d.base));
      chk("seg", 16'(SBOD_SEG_STACK), 16'(d.seg));
      d = dq.pop_front();
      chk("call", 16'(SBOD_OP_CALL), 16'(d.op));
      chk("far", 16'h0001, 16'(d.far));
      chk("override", 16'(SBOD_SEG_EXTRA), 16'(d.seg));
      d = dq.pop_front();
      chk("shift", 16'(SBOD_SH_SHIFT_ARITH_RIGHT), 16'(d.shift_op));
      chk("count", 16'h0003, d.imm);
      d = dq.pop_front();
      chk("size", 16'h0010, d.imm);
      chk("level", 16'h0002, 16'(d.imm2));
      d = dq.pop_front();
      chk("task", 16'(SBOD_OP_LOAD_TASK), 16'(d.op));
   endtask : t_misc
   task automatic t_string;
      u_sbod_fetch_model.slow = 1'b1;
      run('{8'hF3, 8'hA4, 8'hF2, 8'hAE, 8'h0F, 8'h01, 8'hF8, 8'hCC}, 4);
      u_sbod_fetch_model.slow = 1'b0;
      d = dq.pop_front();
      chk("rep", 16'(SBOD_ITER_ALWAYS), 16'(d.iter));
      chk("copy", 16'(SBOD_OP_STG_COPY), 16'(d.op));
      d = dq.pop_front();
      chk("rep ne", 16'(SBOD_ITER_WHILE_NE), 16'(d.iter));
      d = dq.pop_front();
      chk("invalid", 16'h0001, 16'(d.invalid));
      d = dq.pop_front();
      chk("trap", 16'h0003, d.imm);
   endtask : t_string
   task automatic results;
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      #1 rst_b_i = 1'b1;
      t_flags();
      t_misc();
      t_string();
      results();
   end
   initial
   begin
      #20000;
      fail_count++;
      results();
   end
endmodule : tb_sbod_decoder
